//--- hdl/exception_vector_and_irq_control.sv
// exception vector selection, request latching and interrupt control register
//
// Register access over Wishbone and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "irq_defines.svh"

module exception_vector_and_irq_control (
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  srst,
   // wishbone slave
   input  wire logic                  wbCyc,
   input  wire logic                  wbStb,
   input  wire logic                  wbWe,
   input  wire logic [7:0]            wbAdr,
   input  wire logic [3:0]            wbSel,
   input  wire logic [31:0]           wbDatI,
   output logic      [31:0]           wbDatO,
   output logic                       wbAck,
   // external request pins, active low, asynchronous
   input  wire logic                  requestPinN,
   input  wire logic                  nonmaskableRequestPinN,
   // reset and trap sources
   input  wire logic                  powerOnReq,
   input  wire logic                  clockFailReq,
   input  wire logic                  watchdogReq,
   input  wire logic                  illegalOpReq,
   input  wire logic                  softwareTrapReq,
   // peripheral flags
   input  wire logic                  periodicTickFlag,
   input  wire logic [7:0]            timerChannelFlag,
   input  wire logic                  timerOverflowFlag,
   input  wire logic                  pulseAccumOverflowFlag,
   input  wire logic                  pulseAccumEdgeFlag,
   input  wire logic                  spiDoneFlag,
   input  wire logic [3:0]            sciFlags,
   input  wire logic                  converterDoneFlag,
   input  wire logic                  canWakeupFlag,
   input  wire logic [5:0]            canErrorFlags,
   input  wire logic                  canRxFullFlag,
   input  wire logic [2:0]            canTxEmptyFlags,
   // local enables
   input  wire logic                  periodicTickIntEnable,
   input  wire logic [7:0]            timerChannelIntMask,
   input  wire logic                  timerOverflowIntEnable,
   input  wire logic                  pulseAccumOverflowIntEnable,
   input  wire logic                  pulseAccumEdgeIntEnable,
   input  wire logic                  spiIntEnable,
   input  wire logic [3:0]            sciIntEnables,
   input  wire logic                  converterDoneIntEnable,
   input  wire logic                  canWakeupIntEnable,
   input  wire logic [5:0]            canErrorIntEnables,
   input  wire logic                  canRxFullIntEnable,
   input  wire logic [2:0]            canTxEmptyIntEnables,
   // cpu side
   input  wire logic                  maskFlagI,
   input  wire logic                  maskFlagX,
   input  wire logic                  specialMode,
   input  wire logic                  serviceStart,
   input  wire logic                  stopExit,
   output logic      [15:0]           vectorAddr,
   output logic                       vectorValid,
   output logic                       requestPending,
   output logic                       stopResume
);
   import irq_pkg::*;

   // synchronised pins
   logic [1:0]       pinSync;          // bit0 request, bit1 nonmaskable
   logic             irqPinPrev;       // last synced level, for edges
   logic             irqFall;          // falling edge seen this cycle
   // interrupt_control fields and write bookkeeping
   logic             edgeSelect_reg;
   logic             pinConnect_reg;
   logic             stopDelay_reg;
   logic             edgeWritten_reg;  // a write has touched edge select
   logic             delayWritten_reg; // a write has touched stop delay
   logic [7:0]       elevation_reg;    // priority_elevation
   logic             edgeLatch_reg;    // falling edge request latch
   // request evaluation
   logic [`NUM_MASKABLE-1:0] maskReq;
   logic             maskValid;
   logic [7:0]       maskLow;
   logic             irqActive;
   logic             nmiActive;
   req_kind_t        candKind;
   logic [15:0]      candVec;
   // service sequence
   svc_state_t       state_reg;
   req_kind_t        capKind_reg;
   logic [15:0]      capVec_reg;
   logic             vanished;
   // stop exit delay
   logic [12:0]      stopCount_reg;
   logic             stopBusy_reg;
   // bus decode
   logic             busWrite;
   logic             busRead;
   logic [31:0]      readData;

   // two flip-flops ahead of any pin logic
   pin_sync #(.WIDTH(2), .IDLEVAL(2'h3)) u_sync (
      .clk     (clk),
      .srst    (srst),
      .pinRaw  ({nonmaskableRequestPinN, requestPinN}),
      .pinSync (pinSync)
   );

   // previous synced level for edge detection
   always_ff @(posedge clk) begin
      if (srst) begin
         irqPinPrev <= 1'b1;
      end else begin
         irqPinPrev <= pinSync[0];
      end
   end
   assign irqFall = irqPinPrev && !pinSync[0];

   // bus qualifiers: write takes effect at the edge where ack is high
   assign busWrite = wbCyc && wbStb && wbWe && wbAck && wbSel[0];
   assign busRead  = wbCyc && wbStb && !wbWe;

   // edge select: once in normal modes, special skips the first write
   always_ff @(posedge clk) begin
      if (srst) begin
         edgeSelect_reg  <= `RST_EDGE_SELECT;
         edgeWritten_reg <= 1'b0;
      end else if (busWrite && wbAdr == `OFS_INT_CONTROL) begin
         edgeWritten_reg <= 1'b1;
         if (specialMode ? edgeWritten_reg : !edgeWritten_reg) begin
            edgeSelect_reg <= wbDatI[`BIT_EDGE_SELECT];
         end
      end
   end

   // connect bit is writable in every mode
   always_ff @(posedge clk) begin
      if (srst) begin
         pinConnect_reg <= `RST_PIN_CONNECT;
      end else if (busWrite && wbAdr == `OFS_INT_CONTROL) begin
         pinConnect_reg <= wbDatI[`BIT_PIN_CONNECT];
      end
   end

   // stop delay bit: once in normal modes, anytime in special
   always_ff @(posedge clk) begin
      if (srst) begin
         stopDelay_reg    <= `RST_STOP_DELAY;
         delayWritten_reg <= 1'b0;
      end else if (busWrite && wbAdr == `OFS_INT_CONTROL) begin
         delayWritten_reg <= 1'b1;
         if (specialMode || !delayWritten_reg) begin
            stopDelay_reg <= wbDatI[`BIT_STOP_DELAY];
         end
      end
   end

   // elevation register accepts writes only while I is set
   always_ff @(posedge clk) begin
      if (srst) begin
         elevation_reg <= `RST_PRIO_ELEVATION;
      end else if (busWrite && wbAdr == `OFS_PRIO_ELEVATION && maskFlagI) begin
         elevation_reg <= wbDatI[7:0];
      end
   end

   // falling edge latch; a new edge beats the service clear
   always_ff @(posedge clk) begin
      if (srst) begin
         edgeLatch_reg <= 1'b0;
      end else if (edgeSelect_reg && pinConnect_reg && irqFall) begin
         edgeLatch_reg <= 1'b1;
      end else if (state_reg == ST_PICK && capKind_reg == KIND_IRQ_EDGE) begin
         edgeLatch_reg <= 1'b0;
      end
   end

   // external request: edge latch or low level, only when connected
   assign irqActive = pinConnect_reg &&
                      (edgeSelect_reg ? edgeLatch_reg : !pinSync[0]);
   // nonmaskable pin is always level sensed and masked by X alone
   assign nmiActive = !pinSync[1] && !maskFlagX;

   // maskable requests: external pin at index 0, the rest flag and local enable, index 0 highest
   always_comb begin
      maskReq      = '0;
      maskReq[0]   = irqActive;
      maskReq[1]   = periodicTickFlag && periodicTickIntEnable;
      for (int i = 0; i < `NUM_TIMER_CH; i = i + 1) begin
         maskReq[2 + i] = timerChannelFlag[i] && timerChannelIntMask[i];
      end
      maskReq[10]  = timerOverflowFlag && timerOverflowIntEnable;
      maskReq[11]  = pulseAccumOverflowFlag && pulseAccumOverflowIntEnable;
      maskReq[12]  = pulseAccumEdgeFlag && pulseAccumEdgeIntEnable;
      maskReq[13]  = spiDoneFlag && spiIntEnable;
      maskReq[14]  = |(sciFlags & sciIntEnables);
      maskReq[15]  = converterDoneFlag && converterDoneIntEnable;
      maskReq[16]  = canWakeupFlag && canWakeupIntEnable;
      maskReq[17]  = |(canErrorFlags & canErrorIntEnables);
      maskReq[18]  = canRxFullFlag && canRxFullIntEnable;
      maskReq[19]  = |(canTxEmptyFlags & canTxEmptyIntEnables);
   end

   // maskable winner with elevation
   priority_select u_prio (
      .maskReq   (maskReq),
      .elevation (elevation_reg),
      .winValid  (maskValid),
      .winLow    (maskLow)
   );

   // fixed hierarchy: resets, traps, nonmaskable pin, then maskable
   always_comb begin
      candKind = KIND_NONE;
      candVec  = `VEC_TRAP;
      if (powerOnReq) begin
         candKind = KIND_FIXED;
         candVec  = `VEC_RESET;
      end else if (clockFailReq) begin
         candKind = KIND_FIXED;
         candVec  = `VEC_CLOCK_FAIL;
      end else if (watchdogReq) begin
         candKind = KIND_FIXED;
         candVec  = `VEC_WATCHDOG;
      end else if (illegalOpReq) begin
         candKind = KIND_FIXED;
         candVec  = `VEC_TRAP;
      end else if (softwareTrapReq) begin
         candKind = KIND_FIXED;
         candVec  = `VEC_SOFT_TRAP;
      end else if (nmiActive) begin
         candKind = KIND_NMI;
         candVec  = `VEC_NONMASKABLE;
      end else if (!maskFlagI && maskValid) begin
         candVec  = {`VEC_PAGE, maskLow};
         if (maskLow != `VEC_EXT_REQUEST) begin
            candKind = KIND_PERIPH;
         end else if (edgeSelect_reg) begin
            candKind = KIND_IRQ_EDGE;
         end else begin
            candKind = KIND_IRQ_LEVEL;
         end
      end
   end

   // captured request gone before the vector is chosen
   always_comb begin
      vanished = 1'b0;
      if (capKind_reg == KIND_NONE) begin
         vanished = 1'b1;
      end else if (capKind_reg == KIND_NMI) begin
         vanished = pinSync[1];
      end else if (capKind_reg == KIND_IRQ_LEVEL) begin
         vanished = pinSync[0] || !pinConnect_reg;
      end else if (capKind_reg == KIND_PERIPH) begin
         vanished = !maskValid;
      end
   end

   // service sequence: capture at start, choose vector next cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         state_reg   <= ST_IDLE;
         capKind_reg <= KIND_NONE;
         capVec_reg  <= `VEC_TRAP;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (serviceStart) begin
                  state_reg   <= ST_PICK;
                  capKind_reg <= candKind;
                  capVec_reg  <= candVec;
               end
            end
            ST_PICK: begin
               state_reg <= ST_IDLE;
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // vector output, one-cycle valid pulse
   always_ff @(posedge clk) begin
      if (srst) begin
         vectorAddr  <= `VEC_RESET;
         vectorValid <= 1'b0;
      end else if (state_reg == ST_PICK) begin
         vectorAddr  <= vanished ? `VEC_TRAP : capVec_reg;
         vectorValid <= 1'b1;
      end else begin
         vectorValid <= 1'b0;
      end
   end

   // pending indication toward the cpu
   always_ff @(posedge clk) begin
      if (srst) begin
         requestPending <= 1'b0;
      end else begin
         requestPending <= (candKind != KIND_NONE);
      end
   end

   // oscillator settle count on stop exit
   always_ff @(posedge clk) begin
      if (srst) begin
         stopBusy_reg  <= 1'b0;
         stopCount_reg <= '0;
         stopResume    <= 1'b0;
      end else if (stopBusy_reg) begin
         stopCount_reg <= stopCount_reg - 13'h0001;
         stopResume    <= (stopCount_reg == 13'h0001);
         stopBusy_reg  <= (stopCount_reg != 13'h0001);
      end else if (stopExit && stopDelay_reg) begin
         stopBusy_reg  <= 1'b1;
         stopCount_reg <= 13'(`STOP_DELAY_CYCLES);
         stopResume    <= 1'b0;
      end else begin
         stopResume    <= stopExit;
      end
   end

   // read mux
   always_comb begin
      readData = 32'h0000_0000;
      if (wbAdr == `OFS_INT_CONTROL) begin
         readData[`BIT_EDGE_SELECT] = edgeSelect_reg;
         readData[`BIT_PIN_CONNECT] = pinConnect_reg;
         readData[`BIT_STOP_DELAY]  = stopDelay_reg;
      end else if (wbAdr == `OFS_PRIO_ELEVATION) begin
         readData[7:0] = elevation_reg;
      end else if (wbAdr == `OFS_STATUS) begin
         readData[5:0] = {edgeLatch_reg, !pinSync[0], !pinSync[1],
                          stopBusy_reg, requestPending, state_reg};
      end
   end

   // ack one cycle after request, dropped the cycle after
   always_ff @(posedge clk) begin
      if (srst) begin
         wbAck  <= 1'b0;
         wbDatO <= 32'h0000_0000;
      end else begin
         wbAck  <= wbCyc && wbStb && !wbAck;
         wbDatO <= busRead ? readData : 32'h0000_0000;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   // write to the elevation register while unmasked
   sequence elevWriteUnmasked;
      busWrite && wbAdr == `OFS_PRIO_ELEVATION && !maskFlagI;
   endsequence
   // service of a power-on reset
   sequence resetService;
      serviceStart && state_reg == ST_IDLE && powerOnReq ##1 state_reg == ST_PICK;
   endsequence

   ack_pulse_a: assert property (wbAck |=> !wbAck)
      else $error("ack held for two cycles");
   reset_vector_a: assert property (resetService |=> vectorValid && vectorAddr == `VEC_RESET)
      else $error("reset vector wrong");
   elev_locked_a: assert property (elevWriteUnmasked |=> $stable(elevation_reg))
      else $error("elevation written while unmasked");
   edge_latch_a: assert property (edgeSelect_reg && pinConnect_reg && irqFall |=> edgeLatch_reg)
      else $error("falling edge not latched");
   edge_clear_a: assert property (state_reg == ST_PICK && capKind_reg == KIND_IRQ_EDGE
                                  && !irqFall |=> !edgeLatch_reg)
      else $error("edge latch not cleared on service");
   vanish_trap_a: assert property (state_reg == ST_PICK && capKind_reg == KIND_IRQ_LEVEL
                                   && pinSync[0] |=> vectorAddr == `VEC_TRAP)
      else $error("vanished request did not trap");
   stop_wait_a: assert property (!stopBusy_reg && stopExit && stopDelay_reg
                                 |=> !stopResume [*8])
      else $error("stop exit resumed too early");
   stop_fast_a: assert property (!stopBusy_reg && stopExit && !stopDelay_reg |=> stopResume)
      else $error("stop exit without delay not immediate");
   edge_once_a: assert property (!specialMode && edgeWritten_reg && busWrite
                                 |=> $stable(edgeSelect_reg))
      else $error("edge select written twice");
   pin_cut_a: assert property (!pinConnect_reg |-> !maskReq[0])
      else $error("disconnected pin still requests");

endmodule

//--- hdl/irq_defines.svh
// offsets, field positions, reset values, vectors and timing counts of the exception front end
`ifndef IRQ_DEFINES_SVH
`define IRQ_DEFINES_SVH

// register byte addresses
`define OFS_INT_CONTROL      8'h00
`define OFS_PRIO_ELEVATION   8'h04
`define OFS_STATUS           8'h08

// interrupt_control field positions
`define BIT_EDGE_SELECT      7
`define BIT_PIN_CONNECT      6
`define BIT_STOP_DELAY       5

// reset values
`define RST_EDGE_SELECT      1'b0
`define RST_PIN_CONNECT      1'b1
`define RST_STOP_DELAY       1'b1
`define RST_PRIO_ELEVATION   8'hF2

// full vector addresses of the fixed sources
`define VEC_RESET            16'hFFFE
`define VEC_CLOCK_FAIL       16'hFFFC
`define VEC_WATCHDOG         16'hFFFA
`define VEC_TRAP             16'hFFF8
`define VEC_SOFT_TRAP        16'hFFF6
`define VEC_NONMASKABLE      16'hFFF4
`define VEC_PAGE             8'hFF

// low bytes of the maskable vectors, default order
`define VEC_EXT_REQUEST      8'hF2
`define VEC_PERIODIC_TICK    8'hF0
`define VEC_TIMER_CH0        8'hEE
`define VEC_TIMER_STEP       8'h02
`define VEC_TIMER_OVF        8'hDE
`define VEC_PA_OVF           8'hDC
`define VEC_PA_EDGE          8'hDA
`define VEC_SPI              8'hD8
`define VEC_SCI              8'hD6
`define VEC_CONVERTER        8'hD2
`define VEC_CAN_WAKE         8'hD0
`define VEC_CAN_ERROR        8'hC8
`define VEC_CAN_RX           8'hC6
`define VEC_CAN_TX           8'hC4
`define NUM_MASKABLE         20
`define NUM_TIMER_CH         8

// stop exit delay, in E-clock cycles, and its count in clk cycles
`define STOP_DELAY_ECLK      4096
`define STOP_DELAY_CYCLES    (`STOP_DELAY_ECLK)

`endif

//--- hdl/irq_pkg.sv
// types shared by the exception front end
package irq_pkg;

   // service sequence states
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_PICK = 1'b1
   } svc_state_t;

   // kind of the chosen request
   typedef enum logic [2:0] {
      KIND_NONE       = 3'b000,
      KIND_FIXED      = 3'b001,
      KIND_NMI        = 3'b010,
      KIND_IRQ_LEVEL  = 3'b011,
      KIND_IRQ_EDGE   = 3'b100,
      KIND_PERIPH     = 3'b101
   } req_kind_t;

endpackage

//--- hdl/pin_sync.sv
// two flip-flop synchroniser for the request pins
`timescale 1ns/1ps
`include "irq_defines.svh"

module pin_sync #(
   parameter int         WIDTH   = 2,
   parameter logic [1:0] IDLEVAL = 2'h3
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             srst,
   // raw pins and synchronised levels
   input  wire logic [WIDTH-1:0] pinRaw,
   output logic      [WIDTH-1:0] pinSync
);

   logic [WIDTH-1:0] stageOne;        // first stage, read only by stage two

   // one synchroniser per pin
   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : gen_sync
         always_ff @(posedge clk) begin
            if (srst) begin
               stageOne[g] <= IDLEVAL[g];
               pinSync[g]  <= IDLEVAL[g];
            end else begin
               stageOne[g] <= pinRaw[g];
               pinSync[g]  <= stageOne[g];
            end
         end
      end
   endgenerate

endmodule

//--- hdl/priority_select.sv
// picks the winning maskable source, honouring the elevated one
`timescale 1ns/1ps
`include "irq_defines.svh"

module priority_select (
   // gated requests, index 0 is highest by default
   input  wire logic [`NUM_MASKABLE-1:0] maskReq,
   // low byte naming the elevated source
   input  wire logic [7:0]               elevation,
   // winner
   output logic                          winValid,
   output logic      [7:0]               winLow
);

   // low vector byte of maskable source i
   function automatic logic [7:0] vecLow(input int i);
      logic [7:0] v;
      v = 8'h00;
      if (i == 0) begin
         v = `VEC_EXT_REQUEST;
      end else if (i == 1) begin
         v = `VEC_PERIODIC_TICK;
      end else if (i < 2 + `NUM_TIMER_CH) begin
         v = `VEC_TIMER_CH0 - 8'((i - 2) * `VEC_TIMER_STEP);
      end else if (i == 10) begin
         v = `VEC_TIMER_OVF;
      end else if (i == 11) begin
         v = `VEC_PA_OVF;
      end else if (i == 12) begin
         v = `VEC_PA_EDGE;
      end else if (i == 13) begin
         v = `VEC_SPI;
      end else if (i == 14) begin
         v = `VEC_SCI;
      end else if (i == 15) begin
         v = `VEC_CONVERTER;
      end else if (i == 16) begin
         v = `VEC_CAN_WAKE;
      end else if (i == 17) begin
         v = `VEC_CAN_ERROR;
      end else if (i == 18) begin
         v = `VEC_CAN_RX;
      end else begin
         v = `VEC_CAN_TX;
      end
      return v;
   endfunction

   // default order, then elevation overrides; vectors never move
   always_comb begin
      winValid = 1'b0;
      winLow   = 8'h00;
      for (int i = `NUM_MASKABLE - 1; i >= 0; i = i - 1) begin
         if (maskReq[i]) begin
            winValid = 1'b1;
            winLow   = vecLow(i);
         end
      end
      for (int i = 0; i < `NUM_MASKABLE; i = i + 1) begin
         if (maskReq[i] && elevation == vecLow(i)) begin
            winLow = vecLow(i);
         end
      end
   end

endmodule

//--- testbench/request_source.sv
// model of outside logic driving an active-low request pin
`timescale 1ns/1ps

module request_source (
   // clock
   input  wire logic clk,
   // raise asserts, drop is the service handshake
   input  wire logic raise,
   input  wire logic drop,
   // pin, pulled up when released
   output logic      pinN
);
   initial pinN = 1'b1;
   // held low from raise until the handshake
   always @(posedge clk) begin
      if (drop) begin
         pinN <= 1'b1;
      end else if (raise) begin
         pinN <= 1'b0;
      end
   end
endmodule

//--- testbench/exception_vector_and_irq_control_test.sv
// self-checking bench of the exception front end
`timescale 1ns/1ps
`include "irq_defines.svh"

module exception_vector_and_irq_control_test;
   typedef struct {logic [4:0] f; int i; logic [15:0] v;} row_t;
   logic clk = 1'b0, srst = 1'b1, stb = 1'b0, we = 1'b0, iF = 1'b1, xF = 1'b1, spec = 1'b0;
   logic start = 1'b0, exitS = 1'b0, raise = 1'b0, drop = 1'b0, nmiN = 1'b1;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0, q, datO;
   logic [4:0] fx = 5'h00;
   logic [28:0] fl = 29'h0, en = '1;
   logic [15:0] v, vec;
   logic ack, vvld, pend, resume, pinN;
   int errTotal = 0, numChecks = 0, n;
   row_t rows [0:13] = '{'{0,28,16'hFFF0}, '{0,20,16'hFFEE}, '{0,27,16'hFFE0},
      '{0,19,16'hFFDE}, '{0,17,16'hFFDA}, '{0,13,16'hFFD6}, '{0,11,16'hFFD2},
      '{0,6,16'hFFC8}, '{0,1,16'hFFC4}, '{5'h14,20,16'hFFFE}, '{5'h0C,20,16'hFFFC},
      '{5'h04,20,16'hFFFA}, '{5'h02,20,16'hFFF8}, '{5'h01,20,16'hFFF6}};

   always #4 clk = ~clk;

   request_source u_src (.clk(clk), .raise(raise), .drop(drop), .pinN(pinN));

   exception_vector_and_irq_control u_dut (.clk(clk), .srst(srst), .wbCyc(stb), .wbStb(stb),
      .wbWe(we), .wbAdr(adr), .wbSel(4'hF), .wbDatI(dat), .wbDatO(datO), .wbAck(ack),
      .requestPinN(pinN), .nonmaskableRequestPinN(nmiN), .powerOnReq(fx[4]),
      .clockFailReq(fx[3]), .watchdogReq(fx[2]), .illegalOpReq(fx[1]),
      .softwareTrapReq(fx[0]), .periodicTickFlag(fl[28]), .timerChannelFlag(fl[27:20]),
      .timerOverflowFlag(fl[19]), .pulseAccumOverflowFlag(fl[18]),
      .pulseAccumEdgeFlag(fl[17]), .spiDoneFlag(fl[16]), .sciFlags(fl[15:12]),
      .converterDoneFlag(fl[11]), .canWakeupFlag(fl[10]), .canErrorFlags(fl[9:4]),
      .canRxFullFlag(fl[3]), .canTxEmptyFlags(fl[2:0]), .periodicTickIntEnable(en[28]),
      .timerChannelIntMask(en[27:20]), .timerOverflowIntEnable(en[19]),
      .pulseAccumOverflowIntEnable(en[18]), .pulseAccumEdgeIntEnable(en[17]),
      .spiIntEnable(en[16]), .sciIntEnables(en[15:12]), .converterDoneIntEnable(en[11]),
      .canWakeupIntEnable(en[10]), .canErrorIntEnables(en[9:4]),
      .canRxFullIntEnable(en[3]), .canTxEmptyIntEnables(en[2:0]), .maskFlagI(iF),
      .maskFlagX(xF), .specialMode(spec), .serviceStart(start), .stopExit(exitS),
      .vectorAddr(vec), .vectorValid(vvld), .requestPending(pend), .stopResume(resume));

   // compare and count
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      numChecks++;
      if (s !== e) begin
         errTotal++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   // one wishbone classic cycle, held until ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int k;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= {24'h0, d};
      k = 0;
      do begin @(posedge clk); k++; end while (ack !== 1'b1 && k < 50);
      if (ack !== 1'b1) errTotal++;
      q = datO;
      stb <= 1'b0;
      @(posedge clk);
   endtask

   // service request, wait for the vector
   task automatic svc();
      int k;
      @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      k = 0;
      do begin @(posedge clk); k++; end while (vvld !== 1'b1 && k < 9);
      if (vvld !== 1'b1) errTotal++;
      v = vec;
   endtask

   // stop exit, cycles until resume
   task automatic stopRun();
      exitS <= 1'b1;
      @(posedge clk);
      exitS <= 1'b0;
      n = 0;
      do begin @(posedge clk); n++; end while (resume !== 1'b1 && n < 5000);
   endtask

   // short low pulse on the request pin
   task automatic pinPulse();
      raise <= 1'b1;
      @(posedge clk);
      raise <= 1'b0;
      drop <= 1'b1;
      @(posedge clk);
      drop <= 1'b0;
      repeat (5) @(posedge clk);
   endtask

   task automatic printVerdict();
      $display("checks %0d mismatches %0d", numChecks, errTotal);
      if (errTotal == 0 && numChecks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // watchdog
   initial begin
      #100000;
      errTotal++;
      printVerdict();
   end

   initial begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      repeat (3) @(posedge clk);
      chk({16'h0, vec}, 32'hFFFE);
      wb(0, 8'h00, 0); chk(q, 32'h60);
      wb(0, 8'h04, 0); chk(q, 32'hF2);
      wb(0, 8'h0C, 0); chk(q, 32'h0);
      stopRun(); chk(32'(n), `STOP_DELAY_CYCLES + 1);
      wb(1, 8'h04, 8'hE0); wb(0, 8'h04, 0); chk(q, 32'hE0);
      iF <= 1'b0;
      wb(1, 8'h04, 8'hEE); wb(0, 8'h04, 0); chk(q, 32'hE0);
      fl <= 29'h0810_0000;
      svc(); chk({16'h0, v}, 32'hFFE0);
      chk({31'h0, pend}, 32'h1);
      iF <= 1'b1;
      svc(); chk({16'h0, v}, 32'hFFF8);
      chk({31'h0, pend}, 32'h0);
      iF <= 1'b0;
      $display("reset and elevation done");
      foreach (rows[j]) begin
         fx <= rows[j].f;
         fl <= 29'h1 << rows[j].i;
         svc(); chk({16'h0, v}, {16'h0, rows[j].v});
      end
      fx <= 5'h00;
      nmiN <= 1'b0;
      xF <= 1'b0;
      repeat (4) @(posedge clk);
      svc(); chk({16'h0, v}, 32'hFFF4);
      nmiN <= 1'b1;
      xF <= 1'b1;
      fl <= 29'h0;
      $display("vector table done");
      wb(1, 8'h00, 8'hC0); wb(1, 8'h00, 8'h60); wb(0, 8'h00, 0); chk(q, 32'hC0);
      stopRun(); chk(32'(n), 32'h1);
      pinPulse();
      svc(); chk({16'h0, v}, 32'hFFF2);
      svc(); chk({16'h0, v}, 32'hFFF8);
      wb(1, 8'h00, 8'h00);
      pinPulse();
      svc(); chk({16'h0, v}, 32'hFFF8);
      srst <= 1'b1;
      spec <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      repeat (3) @(posedge clk);
      chk({16'h0, vec}, 32'hFFFE);
      wb(1, 8'h00, 8'hE0); wb(0, 8'h00, 0); chk(q, 32'h60);
      raise <= 1'b1;
      repeat (4) @(posedge clk);
      svc(); chk({16'h0, v}, 32'hFFF2);
      raise <= 1'b0;
      drop <= 1'b1;
      @(posedge clk);
      drop <= 1'b0;
      svc(); chk({16'h0, v}, 32'hFFF8);
      wb(1, 8'h00, 8'hE0); wb(0, 8'h00, 0); chk(q, 32'hE0);
      $display("control register done");
      printVerdict();
   end
endmodule
